// *** hw/tsop_link_engine.sv ***
`timescale 1ns/1ns
module tsop_link_engine
  import tsop_pkg::*;
#(
  parameter int RED_LEN = TSOP_RED_LEN
) (
  input  wire logic                  link_clk,
  input  wire logic                  aresetn,
  input  wire logic [TSOP_CFG_W-1:0] cfg_ctrl,
  input  wire logic                  req_tgl,
  input  wire logic [7:0]            hold_byte,
  input  wire logic                  hold_err,
  output logic                       ack_tgl,
  output logic                       run_lvl,
  output logic                       stream_clock,
  output logic                       first_byte_marker,
  output logic                       packet_active_qualifier,
  output logic                       packet_error_flag,
  output logic [7:0]                 parallel_byte_bus,
  output logic                       serial_bit_line
);

  // ----------------------------------------------------------------
  // Crossings into the link domain
  // ----------------------------------------------------------------
  logic                  rst_s1_ff, rst_s2_ff;   // Reset release synchroniser.
  logic [TSOP_CFG_W-1:0] cfg_s1_ff, cfg_s2_ff;   // Quasi-static control.
  logic                  req_s1_ff, req_s2_ff;   // Hand-over request toggle.

  // Each chain is only read at its second stage.
  always_ff @(posedge link_clk) begin
    rst_s1_ff <= aresetn;
    rst_s2_ff <= rst_s1_ff;
    cfg_s1_ff <= cfg_ctrl;
    cfg_s2_ff <= cfg_s1_ff;
    req_s1_ff <= req_tgl;
    req_s2_ff <= req_s1_ff;
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  tsop_link_e state_ff;
  logic       ck_ff;                 // Internal stream clock, true polarity.
  logic [2:0] bit_cnt_ff;            // Bit index in serial mode.
  logic [7:0] pos_ff;                // Index of the next byte in the packet.
  logic [7:0] byte_ff;               // Byte on the parallel bus.
  logic [7:0] shift_ff;              // Remaining serial bits.
  logic       sbit_ff;               // Bit on the serial line.
  logic       sop_ff;                // Current byte is first of packet.
  logic       dat_ff;                // Current byte is a data byte.
  logic       err_ff;                // Current packet is errored.
  logic       ack_ff;                // Hand-over acknowledge toggle.

  wire  lrst      = !rst_s2_ff;
  wire  en        = cfg_s2_ff[TSOP_EN_BIT];
  wire  ser       = cfg_s2_ff[TSOP_SER_BIT];
  wire  red       = cfg_s2_ff[TSOP_RED_BIT] & !ser;   // Serial redundancy not built.
  wire  running   = (state_ff == TSOP_LK_RUN);
  wire  avail     = req_s2_ff ^ ack_ff;
  wire  need_byte = !ser | (bit_cnt_ff == TSOP_LAST_BIT);
  // A launch happens where the internal clock falls.
  wire  fire      = running & ck_ff & !(need_byte & !avail);
  wire  take      = fire & need_byte;
  wire  first     = (pos_ff == 8'h00);
  wire  is_data   = (pos_ff < 8'(TSOP_PKT_LEN));
  wire  [7:0] last_pos = red ? 8'(TSOP_PKT_LEN + RED_LEN - 1)
                             : 8'(TSOP_PKT_LEN - 1);
  wire  [7:0] nxt_pos  = (pos_ff == last_pos) ? 8'h00 : pos_ff + 8'h01;
  wire  nxt_ck         = !running | !ck_ff | !fire;
  // Data-only modes keep the qualifier high whenever the link runs.
  wire  act_int        = running & (red ? dat_ff : 1'b1);

  // ----------------------------------------------------------------
  // State and framing
  // ----------------------------------------------------------------
  // Enable starts the link; disable drops it and restarts framing.
  always_ff @(posedge link_clk) begin
    if (lrst || !en) begin
      state_ff   <= TSOP_LK_IDLE;
      ck_ff      <= 1'b1;
      bit_cnt_ff <= TSOP_LAST_BIT;
      pos_ff     <= 8'h00;
      sop_ff     <= 1'b0;
      dat_ff     <= 1'b0;
      err_ff     <= 1'b0;
    end else begin
      state_ff <= TSOP_LK_RUN;
      ck_ff    <= nxt_ck;
      if (take) begin
        bit_cnt_ff <= 3'h0;
        pos_ff     <= nxt_pos;
        sop_ff     <= first;
        dat_ff     <= is_data;
        err_ff     <= first ? hold_err : err_ff;
      end else if (fire) begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
      end
    end
  end

  // Data path; a new byte is loaded at each take, bits shift MSB first.
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      byte_ff  <= 8'h00;
      shift_ff <= 8'h00;
      sbit_ff  <= 1'b0;
      ack_ff   <= 1'b0;
    end else if (take) begin
      byte_ff  <= hold_byte;
      shift_ff <= {hold_byte[6:0], 1'b0};
      sbit_ff  <= hold_byte[7];
      ack_ff   <= req_s2_ff;
    end else if (fire) begin
      shift_ff <= {shift_ff[6:0], 1'b0};
      sbit_ff  <= shift_ff[7];
    end
  end

  // ----------------------------------------------------------------
  // Pin stage with polarity applied
  // ----------------------------------------------------------------
  // All pins are delayed by the same one cycle, so alignment holds.
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      stream_clock            <= 1'b1;
      first_byte_marker       <= 1'b0;
      packet_active_qualifier <= 1'b0;
      packet_error_flag       <= 1'b0;
      parallel_byte_bus       <= 8'h00;
      serial_bit_line         <= 1'b0;
      run_lvl                 <= 1'b0;
    end else begin
      stream_clock            <= ck_ff ^ cfg_s2_ff[TSOP_INVCLK_BIT];
      first_byte_marker       <= (sop_ff & running) ^ cfg_s2_ff[TSOP_INVSOP_BIT];
      packet_active_qualifier <= act_int ^ cfg_s2_ff[TSOP_INVACT_BIT];
      packet_error_flag       <= (err_ff & running) ^ cfg_s2_ff[TSOP_INVERR_BIT];
      parallel_byte_bus       <= byte_ff;
      serial_bit_line         <= sbit_ff;
      run_lvl                 <= running;
    end
  end

  assign ack_tgl = ack_ff;

endmodule : tsop_link_engine

// *** hw/tsop_pkg.sv ***
package tsop_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  TSOP_CTRL_OFF   = 8'h00;   // Control, read/write.
  localparam logic [7:0]  TSOP_STATUS_OFF = 8'h04;   // Status, read only.
  localparam logic [7:0]  TSOP_RATE_OFF   = 8'h08;   // Nominal clock rate, read only.
  localparam logic [31:0] TSOP_CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] TSOP_CTRL_MASK  = 32'h0000_0F1F;
  localparam int          TSOP_CFG_W      = 12;      // Control bits sent to the link.

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int TSOP_EN_BIT     = 0;   // Link enable.
  localparam int TSOP_SER_BIT    = 1;   // Serial bit mode when set.
  localparam int TSOP_RED_BIT    = 2;   // With redundancy (parallel only).
  localparam int TSOP_MOD_LSB    = 3;   // Modulation select, two bits.
  localparam int TSOP_INVCLK_BIT = 8;   // Invert stream clock.
  localparam int TSOP_INVSOP_BIT = 9;   // Invert first-byte marker.
  localparam int TSOP_INVACT_BIT = 10;  // Invert packet-active qualifier.
  localparam int TSOP_INVERR_BIT = 11;  // Invert packet-error flag.

  // Status fields.
  localparam int TSOP_ST_RUN_BIT  = 0;  // Link side running.
  localparam int TSOP_ST_BUSY_BIT = 1;  // Hand-over word pending.
  localparam int TSOP_ST_CNT_LSB  = 16; // Accepted byte count.

  // Modulation codes.
  localparam logic [1:0] TSOP_MOD_VSB8   = 2'h0;
  localparam logic [1:0] TSOP_MOD_QAM64  = 2'h1;
  localparam logic [1:0] TSOP_MOD_QAM256 = 2'h2;

  // ----------------------------------------------------------------
  // Framing and timing
  // ----------------------------------------------------------------
  localparam int         TSOP_PKT_LEN   = 188;  // Data bytes per packet.
  localparam int         TSOP_RED_LEN   = 20;   // Redundancy bytes per packet.
  localparam logic [2:0] TSOP_LAST_BIT  = 3'h7; // Last bit index of a byte.
  localparam logic [1:0] TSOP_RESP_OKAY = 2'h0;
  localparam logic [1:0] TSOP_RESP_SLV  = 2'h2;

  // Nominal stream clock rates in Hz, per mode and modulation.
  localparam logic [31:0] TSOP_HZ_PAR_VSB8   = 32'd2424080;
  localparam logic [31:0] TSOP_HZ_PAR_QAM64  = 32'd3371290;
  localparam logic [31:0] TSOP_HZ_PAR_QAM256 = 32'd4851330;
  localparam logic [31:0] TSOP_HZ_SER_VSB8   = 32'd19392660;
  localparam logic [31:0] TSOP_HZ_SER_QAM64  = 32'd26970350;
  localparam logic [31:0] TSOP_HZ_SER_QAM256 = 32'd38810700;
  localparam logic [31:0] TSOP_HZ_RED_VSB8   = 32'd2681960;
  localparam logic [31:0] TSOP_HZ_RED_QAM64  = 32'd3658210;
  localparam logic [31:0] TSOP_HZ_RED_QAM256 = 32'd5264220;

  // Link engine states.
  typedef enum logic [0:0] {TSOP_LK_IDLE, TSOP_LK_RUN} tsop_link_e;

endpackage : tsop_pkg

// *** hw/tsop_top.sv ***
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
module tsop_top
  import tsop_pkg::*;
#(
  parameter int ADDR_W  = 8,
  parameter int RED_LEN = TSOP_RED_LEN
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite slave.
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Packet byte source.
  input  wire logic [7:0]        src_byte,
  input  wire logic              src_err,
  input  wire logic              src_valid,
  output logic                   src_ready,
  // Stream link.
  input  wire logic              link_clk,
  output logic                   stream_clock,
  output logic                   first_byte_marker,
  output logic                   packet_active_qualifier,
  output logic                   packet_error_flag,
  output logic [7:0]             parallel_byte_bus,
  output logic                   serial_bit_line
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [31:0]       ctrl_ff;       // Control register.
  logic [ADDR_W-1:0] awaddr_ff;     // Captured write address.
  logic              aw_got_ff;     // Write address held.
  logic [31:0]       wdata_ff;      // Captured write data.
  logic [3:0]        wstrb_ff;      // Captured byte enables.
  logic              w_got_ff;      // Write data held.
  logic [15:0]       cnt_ff;        // Bytes accepted from the source.
  logic [7:0]        hold_byte_ff;  // Word handed to the link.
  logic              hold_err_ff;   // Error tag of the handed word.
  logic              req_ff;        // Hand-over request toggle.
  logic              ack_s1_ff;     // Acknowledge synchroniser, first stage.
  logic              ack_s2_ff;     // Acknowledge synchroniser, second stage.
  logic              run_s1_ff;     // Run level synchroniser, first stage.
  logic              run_s2_ff;     // Run level synchroniser, second stage.
  logic              ack_tgl;       // Acknowledge toggle from the link.
  logic              run_lvl;       // Run level from the link.

  // ----------------------------------------------------------------
  // Write channel decode
  // ----------------------------------------------------------------
  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  // Both halves held and no response outstanding.
  wire do_write = aw_got_ff & w_got_ff & !s_axi_bvalid;
  wire wr_ctrl  = do_write & (awaddr_ff == ADDR_W'(TSOP_CTRL_OFF));
  wire wr_known = (awaddr_ff == ADDR_W'(TSOP_CTRL_OFF))
                | (awaddr_ff == ADDR_W'(TSOP_STATUS_OFF))
                | (awaddr_ff == ADDR_W'(TSOP_RATE_OFF));
  wire nxt_aw_got = do_write ? 1'b0 : (aw_got_ff | aw_take);
  wire nxt_w_got  = do_write ? 1'b0 : (w_got_ff | w_take);
  wire nxt_bvalid = do_write | (s_axi_bvalid & !s_axi_bready);

  // Byte-lane merge of the control write.
  wire [31:0] strb_mask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                           {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  wire [31:0] nxt_ctrl  = ((ctrl_ff & ~strb_mask) | (wdata_ff & strb_mask))
                          & TSOP_CTRL_MASK;

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  wire [1:0]  mod_sel  = ctrl_ff[TSOP_MOD_LSB +: 2];
  wire        mode_ser = ctrl_ff[TSOP_SER_BIT];
  wire        mode_red = ctrl_ff[TSOP_RED_BIT] & !mode_ser;
  // Nominal stream clock rate, half the frequency the link clock source must run at.
  wire [31:0] hz_par   = (mod_sel == TSOP_MOD_VSB8)   ? TSOP_HZ_PAR_VSB8   :
                         (mod_sel == TSOP_MOD_QAM64)  ? TSOP_HZ_PAR_QAM64  :
                         (mod_sel == TSOP_MOD_QAM256) ? TSOP_HZ_PAR_QAM256 : 32'h0000_0000;
  wire [31:0] hz_ser   = (mod_sel == TSOP_MOD_VSB8)   ? TSOP_HZ_SER_VSB8   :
                         (mod_sel == TSOP_MOD_QAM64)  ? TSOP_HZ_SER_QAM64  :
                         (mod_sel == TSOP_MOD_QAM256) ? TSOP_HZ_SER_QAM256 : 32'h0000_0000;
  wire [31:0] hz_red   = (mod_sel == TSOP_MOD_VSB8)   ? TSOP_HZ_RED_VSB8   :
                         (mod_sel == TSOP_MOD_QAM64)  ? TSOP_HZ_RED_QAM64  :
                         (mod_sel == TSOP_MOD_QAM256) ? TSOP_HZ_RED_QAM256 : 32'h0000_0000;
  wire [31:0] rate_val = mode_ser ? hz_ser : (mode_red ? hz_red : hz_par);
  wire [31:0] stat_val = ({16'h0000, 16'h0000} | (32'(cnt_ff) << TSOP_ST_CNT_LSB))
                         | (32'(!src_ready) << TSOP_ST_BUSY_BIT)
                         | (32'(run_s2_ff) << TSOP_ST_RUN_BIT);
  wire        ar_take  = s_axi_arvalid & s_axi_arready;
  wire        rd_ctrl  = (s_axi_araddr == ADDR_W'(TSOP_CTRL_OFF));
  wire        rd_stat  = (s_axi_araddr == ADDR_W'(TSOP_STATUS_OFF));
  wire        rd_rate  = (s_axi_araddr == ADDR_W'(TSOP_RATE_OFF));
  wire        rd_known = rd_ctrl | rd_stat | rd_rate;
  wire [31:0] rd_val   = rd_ctrl ? ctrl_ff :
                         rd_stat ? stat_val :
                         rd_rate ? rate_val : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------
  // Address and data are taken in either order; response follows both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff     <= 1'b0;
      w_got_ff      <= 1'b0;
      awaddr_ff     <= '0;
      wdata_ff      <= 32'h0000_0000;
      wstrb_ff      <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= TSOP_RESP_OKAY;
    end else begin
      aw_got_ff     <= nxt_aw_got;
      w_got_ff      <= nxt_w_got;
      s_axi_awready <= !nxt_aw_got & !nxt_bvalid;
      s_axi_wready  <= !nxt_w_got & !nxt_bvalid;
      s_axi_bvalid  <= nxt_bvalid;
      if (aw_take) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      // Unmapped addresses answer with a slave error.
      if (do_write) begin
        s_axi_bresp <= wr_known ? TSOP_RESP_OKAY : TSOP_RESP_SLV;
      end
    end
  end

  // Control register; enable, mode and polarities steer the link, modulation only selects the rate readback.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= TSOP_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  // One read at a time; data is registered one cycle after the address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= TSOP_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_known ? TSOP_RESP_OKAY : TSOP_RESP_SLV;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Byte hand-over to the link domain
  // ----------------------------------------------------------------
  // The held word stays still until the link returns the toggle.
  wire src_take  = src_valid & src_ready;
  wire hold_free = (ack_s2_ff == req_ff);

  // Acknowledge and run level arrive from the link clock.
  always_ff @(posedge aclk) begin
    ack_s1_ff <= ack_tgl;
    ack_s2_ff <= ack_s1_ff;
    run_s1_ff <= run_lvl;
    run_s2_ff <= run_s1_ff;
  end

  // Single-word handshake; the source stalls while a word is pending.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_ff       <= 1'b0;
      hold_byte_ff <= 8'h00;
      hold_err_ff  <= 1'b0;
      src_ready    <= 1'b0;
      cnt_ff       <= 16'h0000;
    end else begin
      src_ready <= !src_take & hold_free;
      if (src_take) begin
        req_ff       <= !req_ff;
        hold_byte_ff <= src_byte;
        hold_err_ff  <= src_err;
        cnt_ff       <= cnt_ff + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link engine
  // ----------------------------------------------------------------
  tsop_link_engine #(
    .RED_LEN (RED_LEN)
  ) u_link (
    .link_clk                (link_clk),
    .aresetn                 (aresetn),
    .cfg_ctrl                (ctrl_ff[TSOP_CFG_W-1:0]),
    .req_tgl                 (req_ff),
    .hold_byte               (hold_byte_ff),
    .hold_err                (hold_err_ff),
    .ack_tgl                 (ack_tgl),
    .run_lvl                 (run_lvl),
    .stream_clock            (stream_clock),
    .first_byte_marker       (first_byte_marker),
    .packet_active_qualifier (packet_active_qualifier),
    .packet_error_flag       (packet_error_flag),
    .parallel_byte_bus       (parallel_byte_bus),
    .serial_bit_line         (serial_bit_line)
  );

endmodule : tsop_top

// *** verif/test_transport_stream_output_port.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
// Drives the formatter through its bus and byte source in three modes.
module test_transport_stream_output_port;
  import tsop_pkg::*;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, src_byte = '0, parallel_byte_bus;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF, rx_inv = '0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic aclk = 0, link_clk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, src_err = 0, src_valid = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, src_ready;
  logic stream_clock, first_byte_marker, packet_active_qualifier, packet_error_flag;
  logic serial_bit_line, rx_ser = 0;
  int   errors = 0, compares = 0;
  initial forever #20 aclk = ~aclk;
  initial begin #7; forever #32 link_clk = ~link_clk; end
  tsop_top i_dut (.*);
  tsop_rx i_rx (.stream_clock, .first_byte_marker, .packet_active_qualifier,
    .packet_error_flag, .serial_bit_line, .ser_mode(rx_ser), .inv(rx_inv), .parallel_byte_bus);
  // Bus write: each channel is released at the edge that takes it.
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    bit da = 0, dw = 0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
    while (!(da && dw)) begin
      @(posedge aclk);
      if (!da && s_axi_awready) begin da = 1; s_axi_awvalid <= 1'b0; end
      if (!dw && s_axi_wready) begin dw = 1; s_axi_wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw
  // Bus read: returns the data and the response code.
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : axr
  // Control reset value and mask, an unmapped read and every nominal rate.
  task automatic t_regs;
    logic [31:0] hz [9] = '{TSOP_HZ_PAR_VSB8, TSOP_HZ_PAR_QAM64, TSOP_HZ_PAR_QAM256,
      TSOP_HZ_SER_VSB8, TSOP_HZ_SER_QAM64, TSOP_HZ_SER_QAM256, TSOP_HZ_RED_VSB8,
      TSOP_HZ_RED_QAM64, TSOP_HZ_RED_QAM256};
    axr(TSOP_CTRL_OFF, rd, rr);
    `CHK(rd, TSOP_CTRL_RST)
    axw(TSOP_CTRL_OFF, 32'hFFFF_FFFE);
    `CHK(rr, TSOP_RESP_OKAY)
    axr(TSOP_CTRL_OFF, rd, rr);
    `CHK(rd, 32'h0000_0F1E)
    axr(8'h0C, rd, rr);
    `CHK(rr, TSOP_RESP_SLV)
    axw(8'h0C, 32'h0);
    `CHK(rr, TSOP_RESP_SLV)
    for (int k = 0; k < 9; k++) begin
      axw(TSOP_CTRL_OFF, 32'((k / 3) * 2 + (k % 3) * 8));
      axr(TSOP_RATE_OFF, rd, rr);
      `CHK(rd, hz[k])
    end
  endtask : t_regs
  // Two packets, the second one errored, checked at the receiver.
  task automatic t_stream(input logic [11:0] cfg);
    int n = cfg[TSOP_RED_BIT] ? 188 + TSOP_RED_LEN : 188;
    int base = i_rx.cnt;
    int ebase = i_rx.err_cnt;
    axw(TSOP_CTRL_OFF, {20'h00000, cfg});
    repeat (8) @(posedge aclk);
    {rx_ser, rx_inv} = {cfg[TSOP_SER_BIT], cfg[11:8]};
    axw(TSOP_CTRL_OFF, {20'h00000, cfg | 12'h001});
    src_valid <= 1'b1;
    for (int i = 0; i < 2 * n; i++) begin
      src_byte <= 8'(i % n);
      src_err <= (i == n);
      do @(posedge aclk); while (src_ready !== 1'b1);
    end
    src_valid <= 1'b0;
    for (int w = 0; w < 30000 && i_rx.cnt < base + 376; w++) @(posedge aclk);
    `CHK(i_rx.cnt - base, 376)
    `CHK(i_rx.err_cnt - ebase, 188)
    for (int k = 0; k < 376; k++) `CHK(i_rx.got[base + k], 8'(k % 188))
    axr(TSOP_STATUS_OFF, rd, rr);
    `CHK(rd[0], 1'b1)
    axw(TSOP_CTRL_OFF, 32'h0000_0000);
  endtask : t_stream
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (80000) @(posedge aclk);
    errors++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_stream(12'h000);
    t_stream(12'h00A);
    t_stream(12'hF14);
    finish_test();
  end
endmodule : test_transport_stream_output_port
bind tsop_top tsop_chk #(.ADDR_W(ADDR_W), .RED_LEN(RED_LEN)) i_chk (.*);

// *** verif/tsop_chk_assertions.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Stream pin checker, driven by a copy of the control word.
// ----------------------------------------------------------------
module tsop_chk
  import tsop_pkg::*;
#(parameter int ADDR_W = 8, parameter int RED_LEN = TSOP_RED_LEN) (
  input wire logic aclk, aresetn, link_clk, s_axi_awvalid, s_axi_awready,
  input wire logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_arvalid,
  input wire logic s_axi_arready, s_axi_rvalid, src_valid, src_ready, stream_clock,
  input wire logic first_byte_marker, packet_active_qualifier, packet_error_flag,
  input wire logic serial_bit_line,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [7:0]        parallel_byte_bus
);
  logic [11:0] ctl_ff, pk_ff, mk_ff, qa_ff; // Control copy and launch counters.
  logic        lv_ff, ac_ff;                // Previous clock and marker levels.
  wire lv = stream_clock ^ ctl_ff[TSOP_INVCLK_BIT];
  wire ac = first_byte_marker ^ ctl_ff[TSOP_INVSOP_BIT];
  wire qa = packet_active_qualifier ^ ctl_ff[TSOP_INVACT_BIT];
  wire en = ctl_ff[TSOP_EN_BIT];
  wire ln = lv_ff & !lv; // Launching edge of the stream clock.
  wire st = ac & !ac_ff; // First launch of a packet.
  wire [11:0] plen = 12'((ctl_ff[TSOP_RED_BIT] ? 188 + RED_LEN : 188)
                         * (ctl_ff[TSOP_SER_BIT] ? 8 : 1));
  // Takes the control word when software writes it.
  always_ff @(posedge aclk) begin
    if (!aresetn) ctl_ff <= '0;
    else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
             && s_axi_awaddr == TSOP_CTRL_OFF[ADDR_W-1:0]) ctl_ff <= s_axi_wdata[11:0];
  end
  // Counts launches per packet, per marker and per qualified unit.
  always_ff @(posedge link_clk) begin
    lv_ff <= lv;
    ac_ff <= ac;
    if (!aresetn || !en) begin
      pk_ff <= '0;
      mk_ff <= '0;
      qa_ff <= '0;
    end else if (ln) begin
      pk_ff <= st ? 12'h001 : pk_ff + 12'h001;
      mk_ff <= ac ? mk_ff + 12'h001 : 12'h000;
      qa_ff <= st ? 12'h001 : qa_ff + {11'h000, qa};
    end
  end
  a_pins_together: assert property (@(posedge link_clk) disable iff (!aresetn)
    en && ($changed(parallel_byte_bus) || $changed(serial_bit_line)) |-> $changed(stream_clock))
    else $error("data moved without a stream clock edge");
  a_qual_held: assert property (@(posedge link_clk) disable iff (!aresetn)
    en && !ctl_ff[TSOP_RED_BIT] && pk_ff != 12'h000 |-> qa) else $error("qualifier dropped");
  a_error_whole: assert property (@(posedge link_clk) disable iff (!aresetn)
    en && $changed(packet_error_flag) |-> st) else $error("error flag moved mid packet");
  a_packet_len: assert property (@(posedge link_clk) disable iff (!aresetn)
    en && ln && st && pk_ff != 12'h000 |-> pk_ff == plen) else $error("bad packet length");
  a_marker_len: assert property (@(posedge link_clk) disable iff (!aresetn)
    en && $fell(ac) |-> mk_ff == (ctl_ff[TSOP_SER_BIT] ? 12'h008 : 12'h001))
    else $error("bad marker length");
  a_qual_count: assert property (@(posedge link_clk) disable iff (!aresetn)
    en && ctl_ff[TSOP_RED_BIT] && st && pk_ff != 12'h000 |-> qa_ff == 12'h0BC)
    else $error("bad qualified byte count");
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read answer");
  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("late write answer");
  a_source_take: assert property (@(posedge aclk) disable iff (!aresetn)
    src_valid && src_ready |=> !src_ready) else $error("source ready stayed high");
endmodule : tsop_chk

// *** verif/tsop_rx.sv ***
`timescale 1ns/1ns
// Receiving demultiplexer; it samples on the edge opposite the launching one.
module tsop_rx (
  input wire logic stream_clock, first_byte_marker, packet_active_qualifier,
  input wire logic packet_error_flag, serial_bit_line, ser_mode,
  input wire logic [3:0] inv,
  input wire logic [7:0] parallel_byte_bus
);
  logic [7:0] got [0:2047]; // Bytes taken, in arrival order.
  int         cnt = 0;      // Bytes taken.
  int         err_cnt = 0;  // Bytes taken while the error flag was active.
  int         nb = 0;       // Serial bits gathered.
  logic [7:0] sh = 8'h00;   // Serial shift register, first bit is the MSB.
  logic       sop_q = 1'b0; // Marker level at the previous capture.
  // Takes only qualified units; a new marker realigns the serial bits.
  always @(stream_clock) begin
    if (stream_clock ^ inv[0]) begin
      if (packet_active_qualifier ^ inv[2]) begin
        if ((first_byte_marker ^ inv[1]) && !sop_q) nb = 0;
        sh = {sh[6:0], serial_bit_line};
        nb = ser_mode ? nb + 1 : 8;
        if (nb == 8) begin
          got[cnt] = ser_mode ? sh : parallel_byte_bus;
          cnt++;
          if (packet_error_flag ^ inv[3]) err_cnt++;
          nb = 0;
        end
      end
      sop_q = first_byte_marker ^ inv[1];
    end
  end
endmodule : tsop_rx
